// ---- design/sk_map.vh ----
// command codes, field widths and timing counts of the serial key
`ifndef SK_MAP_VH
`define SK_MAP_VH
// ---------------------------------------------
// command words, byte 3 : byte 2 : function code
// ---------------------------------------------
`define SK_CMD_BITS 24
`define SK_CMD_NRD 24'hB00162
`define SK_CMD_NWR 24'hB0019D
`define SK_CMD_PID 24'hB0029D
`define SK_CMD_RCLK 24'hB002F1
`define SK_CMD_WDAY 24'hB002F2
`define SK_CMD_RDAY 24'hB002F3
`define SK_CMD_STOP 24'hB002F4
`define SK_CMD_ARM 24'hB002F5
`define SK_CMD_LOCK 24'hB002F6
// ---------------------------------------------
// field sizes
// ---------------------------------------------
`define SK_ID_BITS 64
`define SK_MEM_BITS 384
`define SK_PID_BITS 128
`define SK_CLK_BITS 20
`define SK_DAY_BITS 9
// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define SK_LFSR_SEED 16'hACE1
`define SK_CLK_MHZ 25
`define SK_OSC_PERIOD_US 82400
`define SK_OSC_CYC (`SK_OSC_PERIOD_US * `SK_CLK_MHZ)
`define SK_FIFO_DEPTH 16
`define SK_FIFO_AW 4
`endif

// ---- design/sk_sync.v ----
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sk_sync #(
	parameter W = 3
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta;
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule
`default_nettype wire

// ---- design/sk_fifo.v ----
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sk_fifo #(
	parameter W = 1,
	parameter D = 16,
	parameter AW = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire clr_i,
	input wire [W-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [W-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	// depth must be a power of two so the pointers wrap on their own
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] fill;
	wire push;
	wire pop;
	assign in_ready_o = (fill != D[AW:0]);
	assign out_valid_o = (fill != {(AW+1){1'b0}});
	assign out_data_o = mem[rp];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
	end
	always @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			fill <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			if (push && !pop) begin
				fill <= fill + 1'b1;
			end else if (pop && !push) begin
				fill <= fill - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/sk_key.v ----
// serial security key with day clock and expiry countdown
`timescale 1ns/1ps
`default_nettype none
`include "sk_map.vh"
module sk_key #(
	parameter [21:0] OSC_CYC = `SK_OSC_CYC,
	parameter FIFO_DEPTH = `SK_FIFO_DEPTH,
	parameter FIFO_AW = `SK_FIFO_AW
) (
	input wire clk_i,
	input wire rst_i,
	input wire ten_i,
	input wire sclk_i,
	input wire dq_i,
	output reg dq_o,
	output reg dq_oe_o,
	output reg locked_o,
	output reg armed_o,
	output reg expired_o,
	output reg osc_on_o,
	output reg overrun_o
);
	// ---------------------------------------------
	// states
	// ---------------------------------------------
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_CMD = 4'h1;
	localparam [3:0] ST_ID = 4'h2;
	localparam [3:0] ST_CMP = 4'h3;
	localparam [3:0] ST_MEM = 4'h4;
	localparam [3:0] ST_GARB = 4'h5;
	localparam [3:0] ST_PID = 4'h6;
	localparam [3:0] ST_RCLK = 4'h7;
	localparam [3:0] ST_RDAY = 4'h8;
	localparam [3:0] ST_WDAY = 4'h9;
	localparam [3:0] ST_IGN = 4'hA;
	localparam [8:0] LAST_ID = `SK_ID_BITS - 1;
	localparam [8:0] LAST_MEM = `SK_MEM_BITS - 1;
	localparam [8:0] LAST_PID = `SK_PID_BITS - 1;
	localparam [8:0] LAST_CLK = `SK_CLK_BITS - 1;
	localparam [8:0] LAST_DAY = `SK_DAY_BITS - 1;
	localparam [8:0] LAST_CMD = `SK_CMD_BITS - 1;
	// ---------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------
	wire [2:0] pins_s;
	wire ten_s;
	wire sclk_s;
	wire dq_s;
	reg ten_d;
	reg sclk_d;
	wire rise_ev;
	wire fall_ev;
	wire ten_up;
	wire ten_down;
	sk_sync #(
		.W(3)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({ten_i, sclk_i, dq_i}),
		.q_o(pins_s)
	);
	assign ten_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign dq_s = pins_s[0];
	assign rise_ev = sclk_s & ~sclk_d & ten_s;
	assign fall_ev = ~sclk_s & sclk_d & ten_s;
	assign ten_up = ten_s & ~ten_d;
	assign ten_down = ~ten_s & ten_d;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ten_d <= 1'b0;
			sclk_d <= 1'b0;
		end else begin
			ten_d <= ten_s;
			sclk_d <= sclk_s;
		end
	end
	// ---------------------------------------------
	// input bit FIFO
	// ---------------------------------------------
	// consumption pauses in a cycle that loads the pin, so the bit counter
	// never moves under the output mux while it is being sampled
	wire fifo_in_ready;
	wire bit_in;
	wire bit_valid;
	wire take;
	sk_fifo #(
		.W(1),
		.D(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(~ten_s),
		.in_data_i(dq_s),
		.in_valid_i(rise_ev),
		.in_ready_o(fifo_in_ready),
		.out_data_o(bit_in),
		.out_valid_o(bit_valid),
		.out_ready_i(~fall_ev)
	);
	assign take = bit_valid & ~fall_ev;
	// ---------------------------------------------
	// stored state
	// ---------------------------------------------
	reg [3:0] st;
	reg [8:0] cnt;
	reg [23:0] cmd;
	reg wr_mode;
	reg miss;
	reg [`SK_ID_BITS-1:0] id_mem;
	reg [`SK_ID_BITS-1:0] match_mem;
	reg [`SK_MEM_BITS-1:0] sec_mem;
	reg [`SK_CLK_BITS-1:0] day_clk;
	reg [`SK_CLK_BITS-1:0] clk_snap;
	reg [`SK_DAY_BITS-1:0] days;
	reg [`SK_DAY_BITS-1:0] days_sh;
	reg [21:0] osc_cnt;
	reg [15:0] lfsr;
	wire [23:0] next_cmd;
	wire next_miss;
	wire osc_tick;
	wire day_wrap;
	assign next_cmd = {bit_in, cmd[23:1]};
	assign next_miss = miss | (bit_in != match_mem[cnt[5:0]]);
	assign osc_tick = osc_on_o && (osc_cnt == OSC_CYC - 22'h1);
	assign day_wrap = osc_tick && (day_clk == {`SK_CLK_BITS{1'b1}});
	// ---------------------------------------------
	// oscillator, day clock and garble source
	// ---------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_cnt <= 22'h0;
			day_clk <= {`SK_CLK_BITS{1'b0}};
		end else if (osc_on_o) begin
			if (osc_tick) begin
				osc_cnt <= 22'h0;
				day_clk <= day_clk + 1'b1;
			end else begin
				osc_cnt <= osc_cnt + 22'h1;
			end
		end
	end
	// garble source for failed matches; free running so it is not replayable
	always @(posedge clk_i) begin
		if (rst_i) begin
			lfsr <= `SK_LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end
	// ---------------------------------------------
	// command sequencer
	// ---------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			st <= ST_IDLE;
			cnt <= 9'h0;
			cmd <= 24'h0;
			wr_mode <= 1'b0;
			miss <= 1'b0;
			id_mem <= {`SK_ID_BITS{1'b0}};
			match_mem <= {`SK_ID_BITS{1'b0}};
			sec_mem <= {`SK_MEM_BITS{1'b0}};
			clk_snap <= {`SK_CLK_BITS{1'b0}};
			days <= {`SK_DAY_BITS{1'b0}};
			days_sh <= {`SK_DAY_BITS{1'b0}};
			locked_o <= 1'b0;
			armed_o <= 1'b0;
			expired_o <= 1'b0;
			osc_on_o <= 1'b0;
		end else begin
			// expiry is sticky: the days count cannot be rewritten once set
			if (day_wrap && !expired_o) begin
				if (days == {`SK_DAY_BITS{1'b0}}) begin
					expired_o <= 1'b1;
				end
				days <= days - 1'b1;
			end
			if (ten_down || !ten_s) begin
				st <= ST_IDLE;
			end else if (ten_up) begin
				st <= ST_CMD;
				cnt <= 9'h0;
			end else if (take) begin
				cnt <= cnt + 9'h1;
				case (st)
				ST_CMD: begin
					cmd <= next_cmd;
					if (cnt == LAST_CMD) begin
						cnt <= 9'h0;
						clk_snap <= day_clk;
						st <= ST_IGN;
						// any complete command word, decoded or not, starts a locked, armed key
						if (armed_o && locked_o) begin
							osc_on_o <= 1'b1;
						end
						case (next_cmd)
						`SK_CMD_NRD: begin
							wr_mode <= 1'b0;
							st <= ST_ID;
							if (armed_o) begin
								osc_on_o <= 1'b1;
							end
						end
						`SK_CMD_NWR: begin
							wr_mode <= 1'b1;
							if (!expired_o) begin
								st <= ST_ID;
							end
						end
						`SK_CMD_PID: begin
							if (!expired_o) begin
								id_mem <= {`SK_ID_BITS{1'b0}};
								match_mem <= {`SK_ID_BITS{1'b0}};
								sec_mem <= {`SK_MEM_BITS{1'b0}};
								st <= ST_PID;
							end
						end
						`SK_CMD_RCLK: begin
							st <= ST_RCLK;
						end
						`SK_CMD_RDAY: begin
							st <= ST_RDAY;
						end
						`SK_CMD_WDAY: begin
							if (!expired_o && !locked_o) begin
								st <= ST_WDAY;
							end
						end
						`SK_CMD_ARM: begin
							armed_o <= 1'b1;
						end
						`SK_CMD_LOCK: begin
							locked_o <= 1'b1;
						end
						`SK_CMD_STOP: begin
							if (!locked_o) begin
								osc_on_o <= 1'b0;
							end
						end
						default: begin
							st <= ST_IGN;
						end
						endcase
					end
				end
				ST_ID: begin
					if (cnt == LAST_ID) begin
						cnt <= 9'h0;
						miss <= 1'b0;
						st <= ST_CMP;
					end
				end
				ST_CMP: begin
					miss <= next_miss;
					if (cnt == LAST_ID) begin
						cnt <= 9'h0;
						if (!next_miss) begin
							st <= ST_MEM;
						end else if (wr_mode) begin
							st <= ST_IGN;
						end else begin
							st <= ST_GARB;
						end
					end
				end
				ST_MEM: begin
					if (wr_mode) begin
						sec_mem[cnt] <= bit_in;
					end
					if (cnt == LAST_MEM) begin
						st <= ST_IGN;
					end
				end
				ST_GARB: begin
					if (cnt == LAST_MEM) begin
						st <= ST_IGN;
					end
				end
				ST_PID: begin
					if (cnt[6]) begin
						match_mem[cnt[5:0]] <= bit_in;
					end else begin
						id_mem[cnt[5:0]] <= bit_in;
					end
					if (cnt == LAST_PID) begin
						st <= ST_IGN;
					end
				end
				ST_RCLK: begin
					if (cnt == LAST_CLK) begin
						st <= ST_IGN;
					end
				end
				ST_RDAY: begin
					if (cnt == LAST_DAY) begin
						st <= ST_IGN;
					end
				end
				ST_WDAY: begin
					days_sh <= {bit_in, days_sh[`SK_DAY_BITS-1:1]};
					if (cnt == LAST_DAY) begin
						// a rollover in this cycle loses to the host's value
						days <= {bit_in, days_sh[`SK_DAY_BITS-1:1]};
						st <= ST_IGN;
					end
				end
				default: begin
					cnt <= cnt;
				end
				endcase
			end
		end
	end
	// ---------------------------------------------
	// data pin driver
	// ---------------------------------------------
	// the pin is loaded on the falling edge and released on the next rising
	// edge, so the host always sees a high impedance gap while it drives
	always @(posedge clk_i) begin
		if (rst_i) begin
			dq_o <= 1'b0;
			dq_oe_o <= 1'b0;
		end else if (!ten_s) begin
			dq_oe_o <= 1'b0;
		end else if (rise_ev) begin
			dq_oe_o <= 1'b0;
		end else if (fall_ev) begin
			dq_oe_o <= 1'b1;
			case (st)
			ST_ID: begin
				dq_o <= id_mem[cnt[5:0]];
			end
			ST_MEM: begin
				dq_o <= sec_mem[cnt];
				dq_oe_o <= ~wr_mode;
			end
			ST_GARB: begin
				dq_o <= lfsr[0];
			end
			ST_RCLK: begin
				dq_o <= clk_snap[cnt[4:0]];
			end
			ST_RDAY: begin
				dq_o <= expired_o | days[cnt[3:0]];
			end
			default: begin
				dq_oe_o <= 1'b0;
			end
			endcase
		end
	end
	// ---------------------------------------------
	// overrun flag
	// ---------------------------------------------
	// a clock edge arriving with the FIFO full is lost; flag it until the
	// next transfer starts
	always @(posedge clk_i) begin
		if (rst_i) begin
			overrun_o <= 1'b0;
		end else if (rise_ev && !fifo_in_ready) begin
			overrun_o <= 1'b1;
		end else if (ten_up) begin
			overrun_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- sim/sk_key_sva.sv ----
// assertion checker for the serial key pins
`timescale 1ns/1ps
`default_nettype none
module sk_key_chk (
	input wire clk_i,
	input wire rst_i,
	input wire ten_i,
	input wire sclk_i,
	input wire dq_oe_o,
	input wire locked_o,
	input wire armed_o,
	input wire expired_o,
	input wire osc_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// pin timing
	// ----
	// six cycles cover the two sync stages plus the output register
	chk_pin_release: assert property (!ten_i [*6] |-> !dq_oe_o)
		else $error("data pin driven with enable low");
	chk_drive_low: assert property ($rose(dq_oe_o) |-> !sclk_i)
		else $error("data pin driven outside low clock phase");
	chk_rise_release: assert property ($rose(sclk_i) |-> ##[2:6] !dq_oe_o)
		else $error("data pin kept after rising clock");
	chk_quiet_start: assert property ($rose(ten_i) |-> !dq_oe_o [*8])
		else $error("output during command word");
	// ----
	// sticky state
	// ----
	chk_lock_stays: assert property (locked_o |=> locked_o)
		else $error("lock released");
	chk_expiry_stays: assert property (expired_o |=> expired_o)
		else $error("expiry released");
	chk_arm_stays: assert property (armed_o |=> armed_o)
		else $error("arm flag lost");
	chk_osc_locked: assert property (locked_o && osc_on_o |=> osc_on_o || expired_o)
		else $error("oscillator stopped while locked");
endmodule
bind sk_key sk_key_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ten_i(ten_i),
	.sclk_i(sclk_i), .dq_oe_o(dq_oe_o), .locked_o(locked_o), .armed_o(armed_o),
	.expired_o(expired_o), .osc_on_o(osc_on_o));
`default_nettype wire

// ---- sim/sk_host.sv ----
// host model driving the key's three-wire link
`timescale 1ns/1ps
`default_nettype none
module sk_host (
	input wire logic clk_i,
	input wire logic dq_i,
	output logic ten_o,
	output logic sclk_o,
	output logic hdq_o,
	output logic hoe_o
);
	// ----
	// link timing
	// ----
	// link idles low: clock parked, pin left to the pull-down
	initial begin
		ten_o = 1'b0;
		sclk_o = 1'b0;
		hdq_o = 1'b0;
		hoe_o = 1'b0;
	end
	// half period of four system clocks gives 320 ns per bit
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// input data is held across the rising edge; output sampled just before it
	task automatic bits(input int n, input logic drv, input logic [383:0] din,
		output logic [383:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b0;
			hoe_o = drv;
			hdq_o = din[i];
			half();
			dout[i] = dq_i;
			sclk_o = 1'b1;
			half();
		end
	endtask
	task automatic start(input logic [23:0] cmd);
		logic [383:0] u;
		ten_o = 1'b1;
		half();
		bits(24, 1'b1, {360'h0, cmd}, u);
	endtask
	task automatic stop();
		hoe_o = 1'b0;
		ten_o = 1'b0;
		half();
		sclk_o = 1'b0;
		half();
	endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the serial key
`timescale 1ns/1ps
`default_nettype none
`include "sk_map.vh"
module tb;
	localparam logic [63:0] IDV = 64'h0123456789ABCDEF;
	localparam logic [63:0] IDN = 64'h1F2E3D4C5B6A7988;
	localparam logic [63:0] MV = 64'hC3A5960F5AA5F00D;
	localparam logic [383:0] DAT = {12{32'h9E37C1B5}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wire ten, sclk, hdq, hoe, dq_o, dq_oe_o, locked_o, armed_o, expired_o, osc_on_o, overrun_o;
	// pull-down holds the pin low when nobody drives it
	wire dq_w = dq_oe_o ? dq_o : (hoe ? hdq : 1'b0);
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int oe_cnt = 0;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (dq_oe_o)
			oe_cnt <= oe_cnt + 1;
	end
	sk_key #(.OSC_CYC(22'h4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ten_i(ten), .sclk_i(sclk),
		.dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .locked_o(locked_o), .armed_o(armed_o),
		.expired_o(expired_o), .osc_on_o(osc_on_o), .overrun_o(overrun_o));
	sk_host u_host (.clk_i(clk_i), .dq_i(dq_w), .ten_o(ten), .sclk_o(sclk), .hdq_o(hdq),
		.hoe_o(hoe));
	// ----
	// compares and transfers
	// ----
	task automatic chk_flag(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk_data(input string n, input logic [383:0] e, input logic [383:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [23:0] c, input int n, output logic [383:0] v);
		u_host.start(c);
		u_host.bits(n, 1'b0, '0, v);
		u_host.stop();
	endtask
	task automatic wdays(input logic [8:0] v);
		logic [383:0] u;
		u_host.start(`SK_CMD_WDAY);
		u_host.bits(9, 1'b1, {375'h0, v}, u);
		u_host.stop();
	endtask
	task automatic pid(input logic [63:0] id);
		logic [383:0] u;
		u_host.start(`SK_CMD_PID);
		u_host.bits(128, 1'b1, {256'h0, MV, id}, u);
		u_host.stop();
	endtask
	task automatic nacc(input logic wr, input logic [63:0] m, input logic [383:0] din,
		output logic [63:0] id, output logic [383:0] dout);
		logic [383:0] u;
		u_host.start(wr ? `SK_CMD_NWR : `SK_CMD_NRD);
		u_host.bits(64, 1'b0, '0, u);
		id = u[63:0];
		u_host.bits(64, 1'b1, {320'h0, m}, u);
		u_host.bits(384, wr, din, dout);
		u_host.stop();
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_bad();
		logic [23:0] bad [6] = '{24'hB00362, 24'hB00062, 24'hA00162, 24'hB00163,
			24'hB002F7, 24'hB00262};
		logic [383:0] v;
		oe_cnt = 0;
		foreach (bad[k])
			rd(bad[k], 64, v);
		chk_data("bad_cmd_oe", 0, oe_cnt);
	endtask
	task automatic t_mem();
		logic [63:0] id;
		logic [383:0] d;
		pid(IDV);
		nacc(1'b1, MV, DAT, id, d);
		nacc(1'b0, MV, '0, id, d);
		chk_data("id_out", IDV, id);
		chk_data("mem_read", DAT, d);
		nacc(1'b1, ~MV, ~DAT, id, d);
		nacc(1'b0, MV, '0, id, d);
		chk_data("mem_kept", DAT, d);
		nacc(1'b0, ~MV, '0, id, d);
		chk_flag("garbled", 1'b1, d !== DAT);
		pid(IDN);
		nacc(1'b0, MV, '0, id, d);
		chk_data("id_new", IDN, id);
		chk_data("erased", 0, d);
		chk_flag("overrun", 1'b0, overrun_o);
	endtask
	task automatic t_days();
		logic [383:0] v;
		rd(`SK_CMD_RDAY, 9, v);
		chk_data("days_reset", 0, v);
		wdays(9'h005);
		rd(`SK_CMD_RDAY, 9, v);
		chk_data("days_a", 9'h005, v);
		wdays(9'h1A3);
		rd(`SK_CMD_RDAY, 9, v);
		chk_data("days_b", 9'h1A3, v);
	endtask
	task automatic t_osc();
		logic [383:0] c1, c2, v;
		logic [63:0] id;
		int t0;
		rd(`SK_CMD_ARM, 0, v);
		chk_flag("armed", 1'b1, armed_o);
		chk_flag("osc_idle", 1'b0, osc_on_o);
		nacc(1'b0, MV, '0, id, v);
		chk_flag("osc_run", 1'b1, osc_on_o);
		t0 = cyc;
		rd(`SK_CMD_RCLK, 20, c1);
		t0 = cyc - t0;
		rd(`SK_CMD_RCLK, 20, c2);
		chk_flag("clk_rate", 1'b1, (c2 - c1) inside {[t0 / 4 - 1 : t0 / 4 + 1]});
		rd(`SK_CMD_STOP, 0, v);
		chk_flag("osc_stop", 1'b0, osc_on_o);
		rd(`SK_CMD_RCLK, 20, c1);
		rd(`SK_CMD_RCLK, 20, c2);
		chk_data("clk_frozen", c1, c2);
		rd(`SK_CMD_LOCK, 0, v);
		chk_flag("locked", 1'b1, locked_o);
		wdays(9'h007);
		rd(`SK_CMD_RDAY, 9, v);
		chk_data("days_locked", 9'h1A3, v);
		chk_flag("osc_armed_lock", 1'b1, osc_on_o);
		rd(`SK_CMD_STOP, 0, v);
		chk_flag("stop_ignored", 1'b1, osc_on_o);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		chk_data("flags_reset", 0, {dq_oe_o, locked_o, armed_o, expired_o, osc_on_o});
		chk_flag("overrun_reset", 1'b0, overrun_o);
		t_bad();
		t_mem();
		t_days();
		t_osc();
		summarize();
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
